// >>> rtl/scwd_board.sv
// Board end: wake-up port decode, block fetch, function dispatch, interrupts
//
// Overview of operation
// R1 - Host must cold-start after every power loss
// R2 - After cold start, functions accepted any order
// R3 - Host reserves wake, channel, invocation, parameter blocks
// R4 - Wake-up block sits at jumper value times sixteen
// R5 - Board zeroes busy flag when cold start completes
// R6 - Port write 02 puts board in reset
// R7 - Port write 00 releases reset before start
// R8 - First start reads wake block, clears busy
// R9 - Later starts read channel control block instead
// R10 - Short-term function: one suppressible completion interrupt
// R11 - Long-term: suppressible interrupt, then forced second
// R12 - Decode function codes 00 through 08
// R13 - Spin-down 0B for disk drives only
// R14 - Codes 0C-11 decoded, accepted per device type
// R15 - Tape-only codes 12 and 14 recognised
// R16 - Enhancements off unless host selects them
// R17 - Post status only while semaphore 00, then FF
// R18 - Device type from two-byte parameter code
// R19 - Function code taken from parameter byte 11
// R20 - Bad or inapplicable code refused with error
`timescale 1ns/10ps
`include "scwd_defines.svh"
module scwd_board
   import scwd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link to the host
   scwd_link_if.board link,
   // Jumpers
   input wire logic [15:0] wake_jumper,
   input wire logic addr20_mode,
   // Drive-level sequencer
   output logic drive_start,
   output logic [7:0] drive_func,
   output logic [7:0] drive_unit,
   output logic [15:0] drive_type,
   input wire logic drive_online_done,
   input wire logic drive_error,
   input wire logic drive_offline_done,
   // Board state
   output logic board_in_reset,
   output logic board_linked
);
   scwd_dev_st_t st_ff;
   scwd_dev_st_t ret_ff;
   logic [19:0] base_ff;
   logic [2:0] cnt_ff;
   logic [2:0] idx_ff;
   logic [7:0] byte_ff [0:4];
   logic [7:0] wdata_ff;
   logic [19:0] ccb_ff;
   logic [19:0] inv_ff;
   logic [19:0] iopb_ff;
   logic [7:0] status_ff;
   logic suppress_ff;
   logic long_ff;
   logic off_pend_ff;
   logic off_irq_ff;
   logic mem_req_ff;
   logic mem_we_ff;
   logic [19:0] mem_addr_ff;
   logic [7:0] mem_wdata_ff;
   logic irq_ff;
   logic drive_start_ff;
   logic [7:0] drive_func_ff;
   logic [7:0] drive_unit_ff;
   logic [15:0] drive_type_ff;
   logic in_reset_ff;
   logic linked_ff;

   // Port decode
   wire port_reset = link.port_wr && (link.port_data == `SCWD_PORT_RESET); // R6
   wire port_release = link.port_wr && (link.port_data == `SCWD_PORT_RELEASE); // R7
   wire port_start = link.port_wr && (link.port_data == `SCWD_PORT_START); // R9

   // Wake-up block address; 16-bit mode drops the top jumper digit
   wire [19:0] wk_addr20 = {wake_jumper, 4'h0};
   wire [19:0] wk_addr16 = {4'h0, wake_jumper[11:0], 4'h0};
   wire [19:0] wk_addr = addr20_mode ? wk_addr20 : wk_addr16; // R4

   // Gathered pointer, three little-endian bytes
   wire [19:0] ptr_bytes = {byte_ff[2][3:0], byte_ff[1], byte_ff[0]};

   // Parameter block fields
   wire [15:0] dev_code = {byte_ff[1], byte_ff[0]}; // R18
   wire [7:0] unit_code = byte_ff[2];
   wire [7:0] fn_code = byte_ff[3]; // R19
   wire [7:0] mod_code = byte_ff[4];

   // Applicability per device type, unknown types accept nothing
   wire [31:0] fn_mask =
      (dev_code == `SCWD_DEV_HARD) ? `SCWD_FN_MASK_HARD :
      ((dev_code == `SCWD_DEV_FLEX8) || (dev_code == `SCWD_DEV_FLEX5)) ?
         `SCWD_FN_MASK_FLEX :
      (dev_code == `SCWD_DEV_TAPE) ? `SCWD_FN_MASK_TAPE : `SCWD_FN_MASK_NONE; // R18
   wire fn_in_range = fn_code < `SCWD_FN_LIMIT;
   wire fn_ok = fn_in_range && fn_mask[fn_code[4:0]]; // R12 R13 R14 R15 R20
   wire [31:0] long_mask = `SCWD_FN_LONG;
   wire fn_long = fn_in_range && long_mask[fn_code[4:0]]; // R11
   // Suppression only when the modifier bit asks; zero keeps old behaviour
   wire fn_noint = mod_code[`SCWD_MOD_NOINT_BIT]; // R16

   // Byte transfer progress
   wire xfer_st = (st_ff == SCWD_D_RD) || (st_ff == SCWD_D_WR);
   wire xfer_last = (idx_ff == (cnt_ff - 3'h1));
   wire notify_irq = (st_ff == SCWD_D_NOTIFY) && !suppress_ff; // R10
   wire off_irq_go = off_irq_ff && !notify_irq && !irq_ff; // Gap after any pulse

   // Main sequencer; reset code aborts whatever is in flight
   always_ff @(posedge clk)
   begin
      if (srst || port_reset) // R6
      begin
         st_ff <= SCWD_D_RESET;
         ret_ff <= SCWD_D_IDLE;
         base_ff <= 20'h00000;
         cnt_ff <= 3'h0;
         linked_ff <= 1'b0;
      end
      else
      begin
         unique case (st_ff)
            SCWD_D_RESET:
               if (port_release) st_ff <= SCWD_D_IDLE; // R7
            SCWD_D_IDLE:
               if (port_start && !linked_ff)
               begin
                  base_ff <= wk_addr + `SCWD_WK_CCB_OFS; // R8
                  cnt_ff <= `SCWD_PTR_BYTES;
                  ret_ff <= SCWD_D_WK_DONE;
                  st_ff <= SCWD_D_RD;
               end
               else if (port_start)
               begin
                  base_ff <= ccb_ff + `SCWD_CCB_INV_OFS; // R9 R2
                  cnt_ff <= `SCWD_PTR_BYTES;
                  ret_ff <= SCWD_D_CCB_DONE;
                  st_ff <= SCWD_D_RD;
               end
            SCWD_D_RD, SCWD_D_WR:
               if (link.mem_ack && xfer_last) st_ff <= ret_ff;
            SCWD_D_WK_DONE:
            begin
               base_ff <= ptr_bytes + `SCWD_CCB_BUSY_OFS; // R5 R8
               cnt_ff <= `SCWD_ONE_BYTE;
               ret_ff <= SCWD_D_LINKED;
               st_ff <= SCWD_D_WR;
            end
            SCWD_D_LINKED:
            begin
               linked_ff <= 1'b1;
               st_ff <= SCWD_D_IDLE;
            end
            SCWD_D_CCB_DONE:
            begin
               base_ff <= ptr_bytes + `SCWD_INV_IOPB_OFS;
               cnt_ff <= `SCWD_PTR_BYTES;
               ret_ff <= SCWD_D_INV_DONE;
               st_ff <= SCWD_D_RD;
            end
            SCWD_D_INV_DONE:
            begin
               base_ff <= ptr_bytes + `SCWD_IOPB_DEV_OFS;
               cnt_ff <= `SCWD_IOPB_BYTES;
               ret_ff <= SCWD_D_IOPB_DONE;
               st_ff <= SCWD_D_RD;
            end
            SCWD_D_IOPB_DONE:
               st_ff <= fn_ok ? SCWD_D_EXEC : SCWD_D_SEM; // R20
            SCWD_D_EXEC:
               if (drive_online_done) st_ff <= SCWD_D_SEM;
            SCWD_D_SEM:
            begin
               base_ff <= inv_ff + `SCWD_INV_SEM_OFS;
               cnt_ff <= `SCWD_ONE_BYTE;
               ret_ff <= SCWD_D_SEM_CHK;
               st_ff <= SCWD_D_RD;
            end
            SCWD_D_SEM_CHK:
               // Host still holds the last status: poll again
               if (byte_ff[0] == `SCWD_SEM_FREE) // R17
               begin
                  base_ff <= inv_ff + `SCWD_INV_STAT_OFS;
                  cnt_ff <= `SCWD_ONE_BYTE;
                  ret_ff <= SCWD_D_SEM_SET;
                  st_ff <= SCWD_D_WR;
               end
               else
                  st_ff <= SCWD_D_SEM;
            SCWD_D_SEM_SET:
            begin
               base_ff <= inv_ff + `SCWD_INV_SEM_OFS; // R17
               cnt_ff <= `SCWD_ONE_BYTE;
               ret_ff <= SCWD_D_NOTIFY;
               st_ff <= SCWD_D_WR;
            end
            SCWD_D_NOTIFY:
               st_ff <= SCWD_D_IDLE;
            default:
               st_ff <= SCWD_D_IDLE;
         endcase
      end
   end

   // Byte bus master; request drops on ack so the host sees fresh edges
   always_ff @(posedge clk)
   begin
      if (srst || port_reset)
      begin
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= 20'h00000;
         idx_ff <= 3'h0;
      end
      else if (xfer_st && link.mem_ack)
      begin
         mem_req_ff <= 1'b0;
         idx_ff <= xfer_last ? 3'h0 : idx_ff + 3'h1;
      end
      else if (xfer_st && !mem_req_ff)
      begin
         mem_req_ff <= 1'b1;
         mem_we_ff <= (st_ff == SCWD_D_WR);
         mem_addr_ff <= base_ff + {17'h00000, idx_ff};
      end
   end

   // Read data capture and write data source
   always_ff @(posedge clk)
   begin
      if (st_ff == SCWD_D_RD && link.mem_ack) byte_ff[idx_ff] <= link.mem_rdata;
      mem_wdata_ff <= wdata_ff;
   end

   // Pointer capture and write data choice per step
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ccb_ff <= 20'h00000;
         inv_ff <= 20'h00000;
         iopb_ff <= 20'h00000;
         wdata_ff <= 8'h00;
         status_ff <= `SCWD_ST_OK;
      end
      else
      begin
         if (st_ff == SCWD_D_WK_DONE) ccb_ff <= ptr_bytes; // R8
         if (st_ff == SCWD_D_CCB_DONE) inv_ff <= ptr_bytes;
         if (st_ff == SCWD_D_INV_DONE) iopb_ff <= ptr_bytes;
         if (st_ff == SCWD_D_WK_DONE) wdata_ff <= `SCWD_BUSY_CLEAR; // R5
         if (st_ff == SCWD_D_SEM_CHK) wdata_ff <= status_ff;
         if (st_ff == SCWD_D_SEM_SET) wdata_ff <= `SCWD_SEM_POSTED; // R17
         if (st_ff == SCWD_D_IOPB_DONE && !fn_ok) status_ff <= `SCWD_ST_ERR; // R20
         if (st_ff == SCWD_D_IOPB_DONE && fn_ok) status_ff <= `SCWD_ST_OK;
         if (st_ff == SCWD_D_EXEC && drive_online_done && drive_error)
            status_ff <= `SCWD_ST_ERR;
      end
   end

   // Drive dispatch; refused codes never pulse the drive
   always_ff @(posedge clk)
   begin
      if (srst || port_reset)
      begin
         drive_start_ff <= 1'b0;
         drive_func_ff <= 8'h00;
         drive_unit_ff <= 8'h00;
         drive_type_ff <= 16'h0000;
         suppress_ff <= 1'b0;
         long_ff <= 1'b0;
      end
      else
      begin
         drive_start_ff <= (st_ff == SCWD_D_IOPB_DONE) && fn_ok; // R20
         if (st_ff == SCWD_D_IOPB_DONE)
         begin
            drive_func_ff <= fn_code;
            drive_unit_ff <= unit_code;
            drive_type_ff <= dev_code;
            suppress_ff <= fn_noint; // R10 R16
            long_ff <= fn_ok && fn_long; // R11
         end
      end
   end

   // Interrupts; off-line completion is never masked and waits two cycles
   // if it collides with a completion pulse. Arrival beats the clear.
   always_ff @(posedge clk)
   begin
      if (srst || port_reset)
      begin
         off_pend_ff <= 1'b0;
         off_irq_ff <= 1'b0;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (st_ff == SCWD_D_NOTIFY && long_ff) off_pend_ff <= 1'b1;
         else if (off_pend_ff && drive_offline_done) off_pend_ff <= 1'b0;
         off_irq_ff <= (off_pend_ff && drive_offline_done) || (off_irq_ff && !off_irq_go); // R11
         irq_ff <= notify_irq || off_irq_go; // R10 R11
      end
   end

   // Status flags for the user side
   always_ff @(posedge clk)
   begin
      if (srst) in_reset_ff <= 1'b1;
      else in_reset_ff <= (port_reset || (in_reset_ff && !port_release)); // R6 R7
   end

   assign link.mem_req = mem_req_ff;
   assign link.mem_we = mem_we_ff;
   assign link.mem_addr = mem_addr_ff;
   assign link.mem_wdata = mem_wdata_ff;
   assign link.irq = irq_ff;
   assign drive_start = drive_start_ff;
   assign drive_func = drive_func_ff;
   assign drive_unit = drive_unit_ff;
   assign drive_type = drive_type_ff;
   assign board_in_reset = in_reset_ff;
   assign board_linked = linked_ff;
endmodule : scwd_board

// >>> rtl/scwd_defines.svh
// Shared constants for the wake-up and command-dispatch link
`ifndef SCWD_DEFINES_SVH
`define SCWD_DEFINES_SVH

// Wake-up port codes
`define SCWD_PORT_RELEASE 8'h00
`define SCWD_PORT_START 8'h01
`define SCWD_PORT_RESET 8'h02

// Block placement and byte offsets
`define SCWD_WK_SHIFT 4'h4
`define SCWD_WK_CCB_OFS 20'h00002
`define SCWD_CCB_BUSY_OFS 20'h00001
`define SCWD_CCB_INV_OFS 20'h00002
`define SCWD_INV_STAT_OFS 20'h00001
`define SCWD_INV_SEM_OFS 20'h00003
`define SCWD_INV_IOPB_OFS 20'h00008
`define SCWD_IOPB_DEV_OFS 20'h00008
`define SCWD_PTR_BYTES 3'h3
`define SCWD_IOPB_BYTES 3'h5
`define SCWD_ONE_BYTE 3'h1

// Flag and status values
`define SCWD_SEM_FREE 8'h00
`define SCWD_SEM_POSTED 8'hff
`define SCWD_BUSY_CLEAR 8'h00
`define SCWD_ST_OK 8'h00
`define SCWD_ST_ERR 8'h80
`define SCWD_MOD_NOINT_BIT 3

// Device type codes
`define SCWD_DEV_HARD 16'h0000
`define SCWD_DEV_FLEX8 16'h0001
`define SCWD_DEV_FLEX5 16'h0003
`define SCWD_DEV_TAPE 16'h0004

// Function applicability, bit n set means function code n accepted
`define SCWD_FN_MASK_HARD 32'h0000f9ff
`define SCWD_FN_MASK_FLEX 32'h000081ff
`define SCWD_FN_MASK_TAPE 32'h00174053
`define SCWD_FN_MASK_NONE 32'h00000000
// Long-term functions: seek 08, rewind 11, space file mark 12
`define SCWD_FN_LONG 32'h00060100
`define SCWD_FN_LIMIT 8'h20

`endif

// >>> rtl/scwd_host.sv
// Host end: wake-up port sequencing, shared memory, status handshake
`timescale 1ns/10ps
`include "scwd_defines.svh"
module scwd_host
   import scwd_pkg::*;
#(
   parameter int AW = 12
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link to the board
   scwd_link_if.host link,
   // User commands
   input wire logic cold_start,
   input wire logic invoke,
   input wire logic [19:0] inv_base,
   // User memory port, write only while the board is quiet
   input wire logic usr_we,
   input wire logic [19:0] usr_addr,
   input wire logic [7:0] usr_wdata,
   // Results
   output logic [7:0] usr_rdata,
   output logic irq_seen,
   output logic [7:0] last_status
);
   logic [7:0] mem [0:(1 << AW) - 1];
   scwd_host_st_t st_ff;
   logic port_wr_ff;
   logic [7:0] port_data_ff;
   logic ack_ff;
   logic [7:0] rdata_ff;
   logic [7:0] usr_rdata_ff;
   logic irq_seen_ff;
   logic [7:0] status_ff;

   // Address folding into the local array
   wire [AW-1:0] dev_idx = link.mem_addr[AW-1:0];
   wire [AW-1:0] usr_idx = usr_addr[AW-1:0];
   wire [19:0] stat_addr = inv_base + `SCWD_INV_STAT_OFS;
   wire [19:0] sem_addr = inv_base + `SCWD_INV_SEM_OFS;
   wire dev_take = link.mem_req && !ack_ff;

   // Reset, release, start: one code per cycle, never reordered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_ff <= SCWD_H_IDLE;
         port_wr_ff <= 1'b0;
         port_data_ff <= 8'h00;
      end
      else
      begin
         port_wr_ff <= 1'b0;
         unique case (st_ff)
            SCWD_H_IDLE:
               if (cold_start)
               begin
                  port_wr_ff <= 1'b1;
                  port_data_ff <= `SCWD_PORT_RESET; // R1 R6
                  st_ff <= SCWD_H_RELEASE;
               end
               else if (invoke)
               begin
                  port_wr_ff <= 1'b1;
                  port_data_ff <= `SCWD_PORT_START; // R9
               end
            SCWD_H_RELEASE:
            begin
               port_wr_ff <= 1'b1;
               port_data_ff <= `SCWD_PORT_RELEASE; // R7
               st_ff <= SCWD_H_START;
            end
            SCWD_H_START:
            begin
               port_wr_ff <= 1'b1;
               port_data_ff <= `SCWD_PORT_START; // R8
               st_ff <= SCWD_H_IDLE;
            end
            default:
               st_ff <= SCWD_H_IDLE;
         endcase
      end
   end

   // Memory: board first, then semaphore release, then user writes
   always_ff @(posedge clk)
   begin
      if (dev_take && link.mem_we) mem[dev_idx] <= link.mem_wdata;
      else if (link.irq) mem[sem_addr[AW-1:0]] <= `SCWD_SEM_FREE; // R17
      else if (usr_we) mem[usr_idx] <= usr_wdata; // R3 R4 R5
      rdata_ff <= mem[dev_idx];
      usr_rdata_ff <= mem[usr_idx];
   end

   // Board bus answer, one cycle after each new request
   always_ff @(posedge clk)
   begin
      if (srst) ack_ff <= 1'b0;
      else ack_ff <= dev_take;
   end

   // Status capture on each interrupt
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irq_seen_ff <= 1'b0;
         status_ff <= 8'h00;
      end
      else
      begin
         irq_seen_ff <= link.irq;
         if (link.irq) status_ff <= mem[stat_addr[AW-1:0]]; // R17
      end
   end

   assign link.port_wr = port_wr_ff;
   assign link.port_data = port_data_ff;
   assign link.mem_ack = ack_ff;
   assign link.mem_rdata = rdata_ff;
   assign usr_rdata = usr_rdata_ff;
   assign irq_seen = irq_seen_ff;
   assign last_status = status_ff;
endmodule : scwd_host

// >>> rtl/scwd_link_if.sv
// Wake-up port, shared-memory byte bus and interrupt between host and board
`timescale 1ns/10ps
interface scwd_link_if (
   input wire logic clk
);
   logic port_wr;
   logic [7:0] port_data;
   logic mem_req;
   logic mem_we;
   logic [19:0] mem_addr;
   logic [7:0] mem_wdata;
   logic mem_ack;
   logic [7:0] mem_rdata;
   logic irq;

   modport board (
      input port_wr, port_data, mem_ack, mem_rdata,
      output mem_req, mem_we, mem_addr, mem_wdata, irq
   );
   modport host (
      output port_wr, port_data, mem_ack, mem_rdata,
      input mem_req, mem_we, mem_addr, mem_wdata, irq
   );
endinterface : scwd_link_if

// >>> rtl/scwd_pkg.sv
// Types shared by both ends of the wake-up link
package scwd_pkg;
   typedef enum logic [3:0] {
      SCWD_D_IDLE = 4'h0,
      SCWD_D_RESET = 4'h1,
      SCWD_D_RD = 4'h2,
      SCWD_D_WR = 4'h3,
      SCWD_D_WK_DONE = 4'h4,
      SCWD_D_LINKED = 4'h5,
      SCWD_D_CCB_DONE = 4'h6,
      SCWD_D_INV_DONE = 4'h7,
      SCWD_D_IOPB_DONE = 4'h8,
      SCWD_D_EXEC = 4'h9,
      SCWD_D_SEM = 4'ha,
      SCWD_D_SEM_CHK = 4'hb,
      SCWD_D_SEM_SET = 4'hc,
      SCWD_D_NOTIFY = 4'hd
   } scwd_dev_st_t;

   typedef enum logic [1:0] {
      SCWD_H_IDLE = 2'h0,
      SCWD_H_RELEASE = 2'h1,
      SCWD_H_START = 2'h2
   } scwd_host_st_t;
endpackage : scwd_pkg

// >>> sim/scwd_link_monitor.sv
// Checker of the wake-up port, memory bus and interrupt between the two ends
`timescale 1ns/10ps
module scwd_link_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Wake-up port
   input wire logic port_wr,
   input wire logic [7:0] port_data,
   // Memory bus and interrupt
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [19:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic irq
);
   logic [19:0] rd_addr_ff;
   logic [7:0] rd_data_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Last byte read; starts as FF so a posting without a prior poll fails
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_addr_ff <= 20'h00000;
         rd_data_ff <= 8'hff;
      end
      else if (mem_ack && !mem_we)
      begin
         rd_addr_ff <= mem_addr;
         rd_data_ff <= mem_rdata;
      end
   end

   chk_ack_follows_req: assert property (mem_req && !mem_ack |=> mem_ack)
      else $error("memory ack missing after request");
   chk_ack_one_cycle: assert property (mem_ack |=> !mem_ack)
      else $error("memory ack longer than one cycle");
   chk_req_drops: assert property (mem_ack |=> !mem_req)
      else $error("memory request held after ack");
   chk_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata))
      else $error("memory request changed before ack");
   chk_irq_single: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   chk_reset_order: assert property (port_wr && port_data == 8'h02 |=>
      port_wr && port_data == 8'h00 ##1 port_wr && port_data == 8'h01)
      else $error("cold start port codes out of order");
   chk_start_fetch: assert property (port_wr && port_data == 8'h01 |->
      ##[1:4] mem_req && !mem_we)
      else $error("no block fetch after start code");
   chk_start_alone: assert property (port_wr && port_data == 8'h01 |=> !port_wr)
      else $error("port write right after start code");
   chk_sem_free: assert property (mem_req && mem_we && mem_wdata == 8'hff |->
      rd_data_ff == 8'h00 && rd_addr_ff == mem_addr)
      else $error("status posted without a free semaphore");
endmodule : scwd_link_monitor

// >>> sim/storage_ctrl_wakeup_cmd_dispatch_tb.sv
// Self-checking bench joining the host and board ends across the link
`timescale 1ns/10ps
`include "scwd_defines.svh"
module storage_ctrl_wakeup_cmd_dispatch_tb;
   localparam logic [19:0] CCB = 20'h00200;
   localparam logic [19:0] INV = 20'h00300;
   localparam logic [19:0] PRM = 20'h00400;
   logic clk, srst, cold_start, invoke, usr_we, addr20_mode;
   logic armed = 1'b0;
   logic drive_online_done, drive_error, drive_offline_done;
   logic drive_start, irq_seen, board_in_reset, board_linked;
   logic [15:0] wake_jumper, drive_type;
   logic [19:0] usr_addr, first_addr;
   logic [7:0] usr_wdata, usr_rdata, last_status, drive_func, drive_unit;
   logic [7:0] exp_q[$];
   logic [15:0] devs [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0002};
   int num_errors, n_checks, n_irq, n_start;

   scwd_link_if lnk (.clk(clk));
   scwd_board scwd_board_i (.clk(clk), .srst(srst), .link(lnk), .wake_jumper(wake_jumper),
      .addr20_mode(addr20_mode), .drive_start(drive_start), .drive_func(drive_func),
      .drive_unit(drive_unit), .drive_type(drive_type), .drive_online_done(drive_online_done),
      .drive_error(drive_error), .drive_offline_done(drive_offline_done),
      .board_in_reset(board_in_reset), .board_linked(board_linked));
   scwd_host scwd_host_i (.clk(clk), .srst(srst), .link(lnk), .cold_start(cold_start),
      .invoke(invoke), .inv_base(INV), .usr_we(usr_we), .usr_addr(usr_addr),
      .usr_wdata(usr_wdata), .usr_rdata(usr_rdata), .irq_seen(irq_seen),
      .last_status(last_status));
   scwd_link_monitor scwd_link_monitor_i (.clk(clk), .srst(srst), .port_wr(lnk.port_wr),
      .port_data(lnk.port_data), .mem_req(lnk.mem_req), .mem_we(lnk.mem_we),
      .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata), .mem_ack(lnk.mem_ack),
      .mem_rdata(lnk.mem_rdata), .irq(lnk.irq));

   // Free-running 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Interrupt and start counts, plus the first address fetched after each start
   always @(posedge clk)
   begin
      if (lnk.irq === 1'b1)
         n_irq++;
      if (drive_start === 1'b1)
         n_start++;
      if (lnk.port_wr === 1'b1 && lnk.port_data === 8'h01)
         armed <= 1'b1;
      else if (armed && lnk.mem_req === 1'b1)
      begin
         first_addr <= lnk.mem_addr;
         armed <= 1'b0;
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Kind 0 waits for a drive start or an interrupt, kind 1 for an interrupt only
   task automatic wait_ev(input int k);
      logic got;
      got = 1'b0;
      for (int i = 0; i < 400 && !got; i++)
      begin
         @(posedge clk);
         #1;
         got = (irq_seen === 1'b1) || (k == 0 && drive_start === 1'b1);
      end
      if (!got)
      begin
         num_errors++;
         $display("TIMEOUT waiting for event kind %0d", k);
         stop_test();
      end
   endtask : wait_ev

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      usr_we <= 1'b1;
      usr_addr <= a;
      usr_wdata <= d;
      @(posedge clk);
      usr_we <= 1'b0;
   endtask : wr

   task automatic wptr(input logic [19:0] a, input logic [19:0] p);
      wr(a, p[7:0]);
      wr(a + 20'h1, p[15:8]);
      wr(a + 20'h2, {4'h0, p[19:16]});
   endtask : wptr

   task automatic rd(input logic [19:0] a, output logic [7:0] d);
      @(posedge clk);
      usr_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      d = usr_rdata;
   endtask : rd

   // Reads a byte until it holds the value; a bounded count guards a hang
   task automatic poll(input logic [19:0] a, input logic [7:0] v);
      logic [7:0] d;
      for (int i = 0; i < 60; i++)
      begin
         rd(a, d);
         if (d === v)
            break;
      end
      check("polled byte", d, v);
      if (d !== v)
         stop_test();
   endtask : poll

   task automatic pulse(input logic inv);
      @(posedge clk);
      if (inv)
         invoke <= 1'b1;
      else
         cold_start <= 1'b1;
      @(posedge clk);
      invoke <= 1'b0;
      cold_start <= 1'b0;
   endtask : pulse

   // Blocks laid out, busy flag preloaded, then the reset, release, start codes
   task automatic cold(input logic [15:0] jmp, input logic m20);
      logic [19:0] w;
      int s0;
      w = m20 ? {jmp, 4'h0} : {4'h0, jmp[11:0], 4'h0};
      s0 = n_start;
      @(posedge clk);
      wake_jumper <= jmp;
      addr20_mode <= m20;
      wptr(w + 20'h2, CCB);
      wr(CCB + 20'h1, 8'hff);
      wptr(CCB + 20'h2, INV);
      wptr(INV + 20'h8, PRM);
      wr(INV + 20'h3, 8'h00);
      pulse(1'b0);
      poll(CCB + 20'h1, 8'h00);
      check("first fetch", first_addr, w + 20'h2);
      repeat (2) @(posedge clk);
      #1;
      check("linked", {board_linked, board_in_reset}, 2'b10);
      check("link starts", n_start - s0, 0);
      $display("test cold start done");
   endtask : cold

   // One function through the blocks, drive answered as the model predicts
   task automatic run_fn(input logic [15:0] dev, input logic [7:0] fn);
      logic [31:0] mask, lm;
      logic acc, lng, sup, err;
      logic [7:0] unit, st;
      int i0, s0;
      lm = `SCWD_FN_LONG;
      mask = (dev == `SCWD_DEV_HARD) ? `SCWD_FN_MASK_HARD :
         (dev == `SCWD_DEV_FLEX8 || dev == `SCWD_DEV_FLEX5) ? `SCWD_FN_MASK_FLEX :
         (dev == `SCWD_DEV_TAPE) ? `SCWD_FN_MASK_TAPE : `SCWD_FN_MASK_NONE;
      acc = fn < `SCWD_FN_LIMIT && mask[fn[4:0]];
      lng = acc && lm[fn[4:0]];
      sup = acc && ($urandom % 3 == 0);
      err = acc && !lng && ($urandom % 4 == 0);
      unit = 8'($urandom % 4);
      exp_q.push_back((acc && !err) ? `SCWD_ST_OK : `SCWD_ST_ERR);
      wr(PRM + 20'h8, dev[7:0]);
      wr(PRM + 20'h9, dev[15:8]);
      wr(PRM + 20'ha, unit);
      wr(PRM + 20'hb, fn);
      wr(PRM + 20'hc, {4'h0, sup, 3'h0});
      wr(INV + 20'h3, 8'h00);
      i0 = n_irq;
      s0 = n_start;
      pulse(1'b1);
      wait_ev(0);
      check("started", drive_start, acc);
      if (acc)
      begin
         check("func", {drive_func, drive_unit, drive_type}, {fn, unit, dev});
         @(posedge clk);
         drive_online_done <= 1'b1;
         drive_error <= err;
         @(posedge clk);
         drive_online_done <= 1'b0;
      end
      if (acc && !sup)
         wait_ev(1);
      if (sup)
      begin
         poll(INV + 20'h3, 8'hff);
         rd(INV + 20'h1, st);
         check("posted status", st, exp_q.pop_front());
         wr(INV + 20'h3, 8'h00);
      end
      else
      begin
         @(posedge clk);
         #1;
         check("status", last_status, exp_q.pop_front());
      end
      if (lng)
      begin
         @(posedge clk);
         drive_offline_done <= 1'b1;
         @(posedge clk);
         drive_offline_done <= 1'b0;
         wait_ev(1);
      end
      repeat (8) @(posedge clk);
      check("irqs", n_irq - i0, (sup ? 0 : 1) + (lng ? 1 : 0));
      check("starts", n_start - s0, acc);
      check("fetch", first_addr, CCB + 20'h2);
   endtask : run_fn

   // Main sequence: reset, link, codes 00 to 15 and 20 hex on every device type, relink
   initial
   begin
      void'($urandom(57563));
      srst = 1'b1;
      {cold_start, invoke, usr_we, addr20_mode} = 4'h0;
      {drive_online_done, drive_error, drive_offline_done} = 3'h0;
      wake_jumper = 16'h0000;
      usr_addr = 20'h00000;
      usr_wdata = 8'h00;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check("reset state", {board_in_reset, board_linked}, 2'b10);
      cold(16'h1010, 1'b1);
      for (int d = 0; d < 5; d++)
         for (int f = 0; f <= 22; f++)
            run_fn(devs[d], (f == 22) ? 8'h20 : 8'(f));
      $display("test function table done");
      cold(16'h1010, 1'b0);
      run_fn(`SCWD_DEV_HARD, 8'h08);
      $display("test relink done");
      stop_test();
   end
endmodule : storage_ctrl_wakeup_cmd_dispatch_tb
